// ---- src/rsq_params.svh ----
// constants for the remote status and query logic
`ifndef RSQ_PARAMS_SVH
`define RSQ_PARAMS_SVH
`define RSQ_SB_DATA_READY   1
`define RSQ_SB_CODE_ERROR   2
`define RSQ_SB_ZERO_DONE    3
`define RSQ_SB_ABNORMAL     4
`define RSQ_SB_REQUEST      6
`define RSQ_SB_RESET        8'h00
`define RSQ_CHAR_SPACE      8'h20
`define RSQ_CHAR_CR         8'h0D
`define RSQ_CHAR_LF         8'h0A
`define RSQ_CHAR_R          8'h52
`define RSQ_CHAR_3          8'h33
`define RSQ_CHAR_1          8'h31
`define RSQ_CHAR_2          8'h32
`endif

// ---- src/rsq_pkg.sv ----
// types for the remote status and query logic
package rsq_pkg;
    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_EXECUTE,
        CMD_KEY_QUERY,
        CMD_REF_RECALL,
        CMD_LEVEL_V,
        CMD_LEVEL_A,
        CMD_OTHER_BAD
    } rsq_cmd_type;
    typedef enum logic [1:0] {
        OUT_IDLE,
        OUT_SPACE,
        OUT_BODY,
        OUT_TERM
    } rsq_out_type;
endpackage : rsq_pkg

// ---- src/rsq_range_field.sv ----
// range field of the key-setting response
`timescale 1ns/1ns
`include "rsq_params.svh"
module rsq_range_field (
    input  wire logic       range_auto,    // automatic ranging on
    input  wire logic [7:0] range_digits,  // manual range as two digits
    output logic [23:0]     field_chars    // three ascii characters
);
    always_comb begin
        if (range_auto) begin
            field_chars = {`RSQ_CHAR_R, `RSQ_CHAR_3, `RSQ_CHAR_1};
        end else begin
            field_chars = {`RSQ_CHAR_R, 4'h3, range_digits[7:4],
                           4'h3, range_digits[3:0]};
        end
    end
endmodule : rsq_range_field

// ---- src/rsq_status.sv ----
// service request status and query response logic
// Function
// - raise service request when any of four request conditions is active
// - clear the status byte once the controller serial polls it
// - every data string starts with exactly one space character
// - key-setting range field reports auto code while auto ranging
// - execute code triggers one measurement like group execute trigger
// - data-ready setting on makes new data set status and request service
// - refuse reference recall when no reference value is stored
`timescale 1ns/1ns
`include "rsq_params.svh"
module rsq_status #(
    parameter int BODY_LEN = 16            // body characters per string
) (
    input  wire logic       clk,            // 125 MHz clock
    input  wire logic       resetn,         // async reset, active low
    input  wire logic       cmd_valid,      // decoded program code strobe
    input  wire rsq_pkg::rsq_cmd_type cmd_code, // decoded program code
    input  wire logic       data_ready_en,  // data-ready setting on
    input  wire logic       meas_done,      // new measurement available
    input  wire logic       internal_err,   // internal error event
    input  wire logic       zero_done,      // zero offset or self test done
    input  wire logic       abnormal,       // abnormal state or test fault
    input  wire logic       ref_stored,     // reference value held
    input  wire logic       range_auto,     // automatic ranging on
    input  wire logic [7:0] range_digits,   // manual range digits
    input  wire logic       serial_poll,    // controller serial polls
    input  wire logic [7:0] body_char,      // body character from source
    input  wire logic       out_ready,      // bus accepts a character
    output logic            srq,            // service request to bus
    output logic [7:0]      status_byte,    // status byte for poll
    output logic            trigger,        // start one measurement
    output logic            out_valid,      // character valid
    output logic [7:0]      out_char_q,     // character to bus
    output logic [5:0]      body_idx,       // body character index
    output logic            cmd_refused     // code refused pulse
);
    logic [7:0]         sb_q;
    rsq_pkg::rsq_out_type st_q;
    logic [5:0]         cnt_q;
    logic [23:0]        range_chars;
    logic               resp_start;
    logic               is_key_q;
    logic [4:1]         ev;

    rsq_range_field u_range (
        .range_auto   (range_auto),
        .range_digits (range_digits),
        .field_chars  (range_chars)
    );

    assign ev[`RSQ_SB_DATA_READY] = data_ready_en & meas_done;
    assign ev[`RSQ_SB_CODE_ERROR] = internal_err |
        (cmd_valid & (cmd_code == rsq_pkg::CMD_OTHER_BAD)) | cmd_refused;
    assign ev[`RSQ_SB_ZERO_DONE]  = zero_done;
    assign ev[`RSQ_SB_ABNORMAL]   = abnormal;

    assign cmd_refused = cmd_valid & (cmd_code == rsq_pkg::CMD_REF_RECALL)
                         & ~ref_stored;

    // sticky condition bits; new event wins over poll clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sb_q <= `RSQ_SB_RESET;
        end else begin
            for (int i = 1; i <= 4; i++) begin
                if (ev[i]) begin
                    sb_q[i-1] <= 1'b1;
                end else if (serial_poll) begin
                    sb_q[i-1] <= 1'b0;
                end
            end
            sb_q[7:4] <= 4'h0;
        end
    end

    assign srq = |sb_q[3:0];
    assign status_byte = {1'b0, srq, 2'b00, sb_q[3:0]};

    assign trigger = cmd_valid & (cmd_code == rsq_pkg::CMD_EXECUTE);

    assign resp_start = cmd_valid & (st_q == rsq_pkg::OUT_IDLE) &
        ((cmd_code == rsq_pkg::CMD_KEY_QUERY) |
         (cmd_code == rsq_pkg::CMD_LEVEL_V) |
         (cmd_code == rsq_pkg::CMD_LEVEL_A) |
         ((cmd_code == rsq_pkg::CMD_REF_RECALL) & ref_stored) |
         meas_done);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q     <= rsq_pkg::OUT_IDLE;
            cnt_q    <= 6'h00;
            is_key_q <= 1'b0;
        end else begin
            unique case (st_q)
                rsq_pkg::OUT_IDLE: begin
                    if (resp_start || (meas_done && !cmd_valid)) begin
                        st_q     <= rsq_pkg::OUT_SPACE;
                        is_key_q <= cmd_valid &
                                    (cmd_code == rsq_pkg::CMD_KEY_QUERY);
                    end
                end
                rsq_pkg::OUT_SPACE: begin
                    if (out_ready) begin
                        st_q  <= rsq_pkg::OUT_BODY;
                        cnt_q <= 6'h00;
                    end
                end
                rsq_pkg::OUT_BODY: begin
                    if (out_ready) begin
                        if (cnt_q == 6'(BODY_LEN - 1)) begin
                            st_q  <= rsq_pkg::OUT_TERM;
                            cnt_q <= 6'h00;
                        end else begin
                            cnt_q <= cnt_q + 6'h01;
                        end
                    end
                end
                rsq_pkg::OUT_TERM: begin
                    if (out_ready) begin
                        if (cnt_q == 6'h01) begin
                            st_q  <= rsq_pkg::OUT_IDLE;
                            cnt_q <= 6'h00;
                        end else begin
                            cnt_q <= 6'h01;
                        end
                    end
                end
            endcase
        end
    end

    assign out_valid = (st_q != rsq_pkg::OUT_IDLE);
    // index of the body char loaded at the next accepted beat
    assign body_idx  = (st_q == rsq_pkg::OUT_BODY) ? cnt_q + 6'h01
                                                   : 6'h00;

    // character register; range field overlays the last three body slots
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_char_q <= `RSQ_CHAR_SPACE;
        end else begin
            unique case (st_q)
                rsq_pkg::OUT_IDLE:  out_char_q <= `RSQ_CHAR_SPACE;
                rsq_pkg::OUT_SPACE: begin
                    if (out_ready) begin
                        if (is_key_q && BODY_LEN == 3) begin
                            out_char_q <= range_chars[23:16];
                        end else if (body_char == `RSQ_CHAR_SPACE) begin
                            out_char_q <= `RSQ_CHAR_R;
                        end else begin
                            out_char_q <= body_char;
                        end
                    end
                end
                rsq_pkg::OUT_BODY: begin
                    if (out_ready) begin
                        if (cnt_q == 6'(BODY_LEN - 1)) begin
                            out_char_q <= `RSQ_CHAR_CR;
                        end else if (is_key_q &&
                                     cnt_q == 6'(BODY_LEN - 4)) begin
                            out_char_q <= range_chars[23:16];
                        end else if (is_key_q &&
                                     cnt_q == 6'(BODY_LEN - 3)) begin
                            out_char_q <= range_chars[15:8];
                        end else if (is_key_q &&
                                     cnt_q == 6'(BODY_LEN - 2)) begin
                            out_char_q <= range_chars[7:0];
                        end else begin
                            out_char_q <= body_char;
                        end
                    end
                end
                rsq_pkg::OUT_TERM: begin
                    if (out_ready) begin
                        out_char_q <= (cnt_q == 6'h00) ? `RSQ_CHAR_LF
                                                       : `RSQ_CHAR_SPACE;
                    end
                end
            endcase
        end
    end

    property p_poll_clears;
        @(posedge clk) disable iff (!resetn)
        (serial_poll && ev == 4'h0) |=> (status_byte == 8'h00);
    endproperty
    a_poll_clears: assert property (p_poll_clears)
        else $error("status not cleared by poll");

    property p_event_srq;
        @(posedge clk) disable iff (!resetn)
        (|ev) |=> srq && status_byte[6];
    endproperty
    a_event_srq: assert property (p_event_srq)
        else $error("event did not raise service request");

    property p_ready_bit;
        @(posedge clk) disable iff (!resetn)
        (data_ready_en && meas_done) |=> status_byte[0];
    endproperty
    a_ready_bit: assert property (p_ready_bit)
        else $error("data ready bit not set");

    property p_zero_bits;
        @(posedge clk) disable iff (!resetn)
        status_byte[7] == 1'b0 && status_byte[5:4] == 2'b00 &&
        (status_byte[6] == |status_byte[3:0]);
    endproperty
    a_zero_bits: assert property (p_zero_bits)
        else $error("status byte layout wrong");

    property p_one_space;
        @(posedge clk) disable iff (!resetn)
        (st_q == rsq_pkg::OUT_SPACE && out_ready)
        |=> out_char_q != `RSQ_CHAR_SPACE;
    endproperty
    a_one_space: assert property (p_one_space)
        else $error("second leading space sent");

    property p_trigger;
        @(posedge clk) disable iff (!resetn)
        trigger == (cmd_valid && cmd_code == rsq_pkg::CMD_EXECUTE);
    endproperty
    a_trigger: assert property (p_trigger)
        else $error("trigger without execute code");

    property p_refuse;
        @(posedge clk) disable iff (!resetn)
        (cmd_valid && cmd_code == rsq_pkg::CMD_REF_RECALL && !ref_stored)
        |=> status_byte[1];
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("recall without reference not flagged");

    property p_auto_range;
        @(posedge clk) disable iff (!resetn)
        range_auto |->
        range_chars == {`RSQ_CHAR_R, `RSQ_CHAR_3, `RSQ_CHAR_1};
    endproperty
    a_auto_range: assert property (p_auto_range)
        else $error("auto range code not reported");
endmodule : rsq_status

// ---- sim/rsq_ctrl_model.sv ----
// bus controller model: serial polls and reads output strings
`timescale 1ns/1ns
module rsq_ctrl_model (
    input  wire logic        clk,         // 125 MHz clock
    input  wire logic        resetn,      // async reset, active low
    input  wire logic        poll_go,     // bench asks for a poll
    input  wire logic        slow,        // take a char every other cycle
    input  wire logic        clr,         // start a new string record
    input  wire logic        out_valid,   // char offered
    input  wire logic [7:0]  out_char_q,  // char from device
    output logic             serial_poll, // poll strobe
    output logic             out_ready,   // char taken
    output logic [7:0]       first_q,     // first char of string
    output logic [7:0]       second_q,    // second char of string
    output logic [7:0]       cnt_q,       // chars taken
    output logic [39:0]      tail_q       // last five chars
);
    logic gap_q;
    assign serial_poll = poll_go && !out_valid;
    assign out_ready = out_valid && !(slow && gap_q);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) gap_q <= 1'b0;
        else gap_q <= !gap_q;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {cnt_q, first_q, second_q, tail_q} <= '0;
        end else if (clr) begin
            cnt_q <= 8'h00;
        end else if (out_ready) begin
            if (cnt_q == 8'h00) first_q <= out_char_q;
            if (cnt_q == 8'h01) second_q <= out_char_q;
            cnt_q <= cnt_q + 8'h01;
            tail_q <= {tail_q[31:0], out_char_q};
        end
    end
endmodule : rsq_ctrl_model

// ---- sim/rsq_status_tb_top.sv ----
// testbench for the remote status and query logic
`timescale 1ns/1ns
module rsq_status_tb_top;
    localparam int BL = 4;
    logic clk, resetn, cmd_valid, data_ready_en, meas_done, internal_err;
    logic zero_done, abnormal, ref_stored, range_auto, serial_poll;
    logic out_ready, poll_go, slow, clr, body_sp, srq, trigger, out_valid;
    logic cmd_refused;
    logic [7:0] range_digits, body_char, status_byte, out_char_q;
    logic [7:0] first_q, second_q, cnt_q;
    logic [5:0] body_idx;
    logic [39:0] tail_q;
    rsq_pkg::rsq_cmd_type cmd_code;
    int failures, cmp_count;
    assign body_char = (body_sp && body_idx == 6'h00) ? 8'h20
                                                      : 8'h41 + body_idx;
    rsq_status #(.BODY_LEN(BL)) rsq_status_inst (.clk(clk), .resetn(resetn),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .data_ready_en(data_ready_en), .meas_done(meas_done),
        .internal_err(internal_err), .zero_done(zero_done),
        .abnormal(abnormal), .ref_stored(ref_stored),
        .range_auto(range_auto), .range_digits(range_digits),
        .serial_poll(serial_poll), .body_char(body_char),
        .out_ready(out_ready), .srq(srq), .status_byte(status_byte),
        .trigger(trigger), .out_valid(out_valid), .out_char_q(out_char_q),
        .body_idx(body_idx), .cmd_refused(cmd_refused));
    rsq_ctrl_model rsq_ctrl_model_inst (.clk(clk), .resetn(resetn),
        .poll_go(poll_go), .slow(slow), .clr(clr), .out_valid(out_valid),
        .out_char_q(out_char_q), .serial_poll(serial_poll),
        .out_ready(out_ready), .first_q(first_q), .second_q(second_q),
        .cnt_q(cnt_q), .tail_q(tail_q));
    task automatic check(input logic [23:0] got, exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got,
                     exp);
        end
    endtask : check
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic poll();
        poll_go = 1'b1;
        tick();
        poll_go = 1'b0;
        check(status_byte, 8'h00, "status after poll");
    endtask : poll
    task automatic drain();
        int i;
        for (i = 0; i < 100 && cnt_q != BL + 3; i++) tick();
        check(cnt_q, BL + 3, "string length");
        check(first_q, 8'h20, "leading space");
        check(second_q == 8'h20, 1'b0, "second space");
        check(tail_q[15:0], 16'h0D0A, "terminator");
        clr = 1'b1;
        tick();
        clr = 1'b0;
    endtask : drain
    task automatic t_status();
        meas_done = 1'b1;
        tick();
        meas_done = 1'b0;
        check(status_byte, 8'h00, "ready off");
        drain();
        {data_ready_en, body_sp, meas_done} = 3'b111;
        tick();
        meas_done = 1'b0;
        check({srq, status_byte}, 9'h141, "data ready");
        drain();
        poll();
        for (int i = 0; i < 3; i++) begin
            {abnormal, zero_done, internal_err} = 3'b001 << i;
            tick();
            {abnormal, zero_done, internal_err} = 3'b000;
            check({srq, status_byte}, 9'h140 | (9'h002 << i), "cond");
            poll();
        end
        {abnormal, zero_done, internal_err, meas_done} = 4'b1111;
        tick();
        {abnormal, zero_done, internal_err, meas_done} = 4'b0000;
        check(status_byte, 8'h4F, "all four");
        drain();
        poll();
        {zero_done, poll_go} = 2'b11;
        tick();
        {zero_done, poll_go} = 2'b00;
        check(status_byte, 8'h44, "event beats poll");
        poll();
        $display("test status done");
    endtask : t_status
    task automatic t_cmds();
        logic s, e;
        for (int c = 1; c < 7; c++) begin
            cmd_code = rsq_pkg::rsq_cmd_type'(c);
            s = cmd_code inside {rsq_pkg::CMD_KEY_QUERY, rsq_pkg::CMD_LEVEL_V,
                                 rsq_pkg::CMD_LEVEL_A};
            e = cmd_code inside {rsq_pkg::CMD_REF_RECALL,
                                 rsq_pkg::CMD_OTHER_BAD};
            cmd_valid = 1'b1;
            #1;
            check(trigger, c == 1, "trigger");
            check(cmd_refused, c == 3, "refused");
            tick();
            cmd_valid = 1'b0;
            check(status_byte, e ? 8'h42 : 8'h00, "code status");
            if (s) drain();
            else check(out_valid, 1'b0, "no string");
            if (c == 2) check(tail_q[39:16], 24'h52_3331, "auto range");
            poll();
        end
        {ref_stored, cmd_valid} = 2'b11;
        cmd_code = rsq_pkg::CMD_REF_RECALL;
        #1;
        check(cmd_refused, 1'b0, "recall stored");
        tick();
        {range_auto, slow, cmd_valid} = 3'b010;
        drain();
        cmd_valid = 1'b1;
        cmd_code = rsq_pkg::CMD_KEY_QUERY;
        tick();
        cmd_valid = 1'b0;
        drain();
        check(tail_q[39:16], 24'h52_3132, "manual range");
        // trigger and read, twice; first result is thrown away
        for (int r = 0; r < 2; r++) begin
            cmd_code = rsq_pkg::CMD_EXECUTE;
            cmd_valid = 1'b1;
            tick();
            cmd_valid = 1'b0;
            meas_done = 1'b1;
            tick();
            meas_done = 1'b0;
            check(status_byte, 8'h41, "ready after trigger");
            drain();
            if (r == 1) check(tail_q[39:16], 24'h42_4344, "trig read");
            poll();
        end
        $display("test commands done");
    endtask : t_cmds
    task automatic end_sim();
        $display("comparisons %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #200000;
        failures++;
        end_sim();
    end
    initial begin
        {resetn, cmd_valid, data_ready_en, meas_done, internal_err} = '0;
        {zero_done, abnormal, ref_stored, poll_go, slow, clr, body_sp} = '0;
        {range_auto, range_digits} = {1'b1, 8'h12};
        cmd_code = rsq_pkg::CMD_NONE;
        tick(6);
        resetn = 1'b1;
        check({srq, out_valid, status_byte}, 10'h000, "reset");
        t_status();
        t_cmds();
        end_sim();
    end
endmodule : rsq_status_tb_top
